/* File: design/tbs_pkg.sv */
// Constants and carrier types of the tile boot sequencer
package tbs_pkg;
    // ========================================================
    // Timing
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          RST_PHASE_NS  = 15000;
    localparam logic [7:0]  RST_CYC       =
        8'((RST_PHASE_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
    localparam int          LINK_EN_NS    = 200;
    localparam logic [1:0]  LINK_EN_CYC   =
        2'((LINK_EN_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
    localparam int          SPI_HZ        = 2_500_000;
    localparam logic [3:0]  SPI_HALF_CYC  = 4'(CLK_HZ / (2 * SPI_HZ));
    // ========================================================
    // Image, CRC and protocol values
    localparam logic [31:0] CRC_POLY      = 32'hedb88320;
    localparam logic [31:0] CRC_INIT      = 32'hffffffff;
    localparam logic [31:0] CRC_BYPASS    = 32'h0d15ab1e;
    localparam logic [31:0] NULL_CHAN     = 32'h0000ff02;
    localparam logic [7:0]  SPI_READ      = 8'h03;
    localparam logic [23:0] SPI_ADDR      = 24'h000000;
    localparam logic [7:0]  TOK_END       = 8'h01;
    localparam int          SEC_BOOT_BIT  = 5;
    localparam logic [10:0] OTP_START     = 11'h000;
    localparam logic [15:0] RAM_START     = 16'h0000;
    // PLL ratio times 100
    localparam logic [15:0] PLL_R00       = 16'h0c03;
    localparam logic [15:0] PLL_R01       = 16'h0190;
    localparam logic [15:0] PLL_R10       = 16'h0341;
    localparam logic [15:0] PLL_R11       = 16'h07d0;
    // Synchroniser lanes
    localparam int          SY_MISO = 0;
    localparam int          SY_LCLK = 1;
    localparam int          SY_LIN0 = 2;
    localparam int          SY_LIN1 = 3;
    localparam int          SY_STR  = 4;
    // ========================================================
    // Types
    typedef enum logic [1:0] {
        BS_TEST = 2'b00, BS_RSVD = 2'b01, BS_LINK = 2'b10, BS_SPI = 2'b11
    } tbs_strap_e;
    typedef enum logic [1:0] {
        SRC_NONE = 2'b00, SRC_LINK = 2'b01, SRC_SPI = 2'b10, SRC_OTP = 2'b11
    } tbs_src_e;
    typedef enum logic [1:0] {
        PH_SIZE = 2'b00, PH_PROG = 2'b01, PH_CRC = 2'b10, PH_DONE = 2'b11
    } tbs_ph_e;
    typedef struct packed {
        logic sclk;
        logic ss_n;
        logic mosi;
    } tbs_spi_s;
    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [7:0]  data;
    } tbs_ram_s;
endpackage : tbs_pkg

/* File: design/tbs_top.sv */
// Tile boot sequencer: reset phase, source select, image load and check
// Operation
// - Hold reset, keep pins high impedance
// - Reset phase 15 us, then pulls, boot
// - Upper straps pick test, link or SPI
// - Security bit 5 forces boot from OTP
// - Image is size, program words, CRC
// - Bypass word skips the CRC check
// - Size and CRC words low byte first
// - Load from lowest RAM address, jump there
// - Reflected CRC-32 over size and program
// - SPI master clock at 2.5 MHz
// - One READ command, address zero, stream
// - SPI clock polarity 0, phase 0
// - SPI bytes shifted least bit first
// - Four fixed SPI pins, not configurable
// - Link enabled about 200 ns after start
// - Link drops pull-downs, drives outputs low
// - Link ack word, image, END in, END out unless ack is null channel
// - Secure boot reads OTP from address 0
// - Lower straps set boot PLL ratio
`timescale 1ns/1ns
module tbs_top
    import tbs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [1:0]  boot_src_strap,
    input  wire logic        pll_ratio_strap_low,
    input  wire logic        pll_ratio_strap_high,
    input  wire logic [31:0] security_reg,
    input  wire logic        spi_miso,
    input  wire logic        link_clk,
    input  wire logic [1:0]  link_in,
    input  wire logic [31:0] otp_rdata,
    output tbs_spi_s         spi,
    output logic             spi_oe_n,
    output logic [1:0]       link_out,
    output logic             link_oe_n,
    output logic             link_pd_en,
    output logic             gpio_hiz,
    output logic             gpio_pull_en,
    output logic             otp_rd,
    output logic [10:0]      otp_addr,
    output tbs_ram_s         ram,
    output logic             core_rst_n,
    output logic             jump,
    output logic [15:0]      jump_addr,
    output logic             crc_fail,
    output logic             wait_test,
    output logic             chan0_alloc,
    output logic [15:0]      pll_mult
);
    typedef enum logic [3:0] {
        ST_RST = 4'h0, ST_SEL = 4'h1, ST_TEST = 4'h2, ST_SPI_CMD = 4'h3,
        ST_LOAD = 4'h4, ST_LK_EN = 4'h5, ST_LK_ACK = 4'h6,
        ST_LK_ENDIN = 4'h7, ST_LK_ENDOUT = 4'h8, ST_CHECK = 4'h9,
        ST_JUMP = 4'ha, ST_FAIL = 4'hb
    } tbs_st_e;

    function automatic logic [31:0] crc_upd(input logic [31:0] c,
                                            input logic [7:0]  b);
        logic [31:0] r;
        r = c ^ {24'h0, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_upd

    tbs_st_e     state_ff;
    tbs_src_e    src_ff;
    tbs_ph_e     ph_ff;
    logic [7:0]  sync1_ff, sync2_ff, rst_cnt_ff;
    logic        lclk_d_ff, link_en_ff, img_done_ff, cmd_done_ff;
    logic [1:0]  en_cnt_ff, bc_ff, acnt_ff;
    logic [31:0] word_ff, size_ff, bytes_ff, crc_ff, rx_crc_ff, ack_ff;
    logic [3:0]  div_ff, ltx_cnt_ff;
    logic [5:0]  scnt_ff;
    logic [31:0] tx_ff;
    logic [7:0]  srx_ff, sbyte_ff, lsh_ff, lk_byte_ff, otp_byte;
    logic        spi_vld_ff, lk_vld_ff, lk_ctl_ff, ltx_done_ff;
    logic [2:0]  lbit_ff, ob_ff;
    logic [31:0] otp_word_ff;
    logic        otp_vld_ff;
    logic        spi_on, lclk_rise, src_vld, img_ok;
    logic [7:0]  src_byte;
    logic [31:0] nxt_word, nxt_crc;

    // ========================================================
    // Input synchronisers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
        end else begin
            sync1_ff <= {pll_ratio_strap_high, pll_ratio_strap_low,
                         boot_src_strap, link_in, link_clk, spi_miso};
            sync2_ff <= sync1_ff;
        end
    end

    // ========================================================
    // Reset phase, pins and PLL ratio
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_cnt_ff   <= 8'h00;
            gpio_hiz     <= 1'b1;
            gpio_pull_en <= 1'b0;
            pll_mult     <= PLL_R00;
        end else if (state_ff == ST_RST) begin
            rst_cnt_ff <= rst_cnt_ff + 8'h01;
            if (rst_cnt_ff == RST_CYC - 8'h01) begin
                gpio_hiz     <= 1'b0;
                gpio_pull_en <= 1'b1;
                case (sync2_ff[SY_STR+3:SY_STR+2])
                    2'b00:   pll_mult <= PLL_R00;
                    2'b01:   pll_mult <= PLL_R01;
                    2'b10:   pll_mult <= PLL_R10;
                    default: pll_mult <= PLL_R11;
                endcase
            end
        end
    end

    // ========================================================
    // Boot sequence
    assign img_ok = (rx_crc_ff == CRC_BYPASS)
                 || (~crc_ff == rx_crc_ff);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff    <= ST_RST;
            src_ff      <= SRC_NONE;
            en_cnt_ff   <= 2'b00;
            acnt_ff     <= 2'b00;
            ack_ff      <= 32'h0;
            link_en_ff  <= 1'b0;
            core_rst_n  <= 1'b0;
            jump        <= 1'b0;
            jump_addr   <= RAM_START;
            crc_fail    <= 1'b0;
            wait_test   <= 1'b0;
            chan0_alloc <= 1'b0;
        end else begin
            case (state_ff)
                ST_RST:
                    if (rst_cnt_ff == RST_CYC - 8'h01) state_ff <= ST_SEL;
                ST_SEL: begin
                    if (security_reg[SEC_BOOT_BIT]) begin
                        src_ff   <= SRC_OTP;
                        state_ff <= ST_LOAD;
                    end else begin
                        case (sync2_ff[SY_STR+1:SY_STR])
                            BS_LINK: begin
                                src_ff   <= SRC_LINK;
                                state_ff <= ST_LK_EN;
                            end
                            BS_SPI: begin
                                src_ff   <= SRC_SPI;
                                state_ff <= ST_SPI_CMD;
                            end
                            default: state_ff <= ST_TEST;
                        endcase
                    end
                end
                ST_TEST: wait_test <= 1'b1;
                ST_SPI_CMD: if (cmd_done_ff) state_ff <= ST_LOAD;
                ST_LK_EN: begin
                    en_cnt_ff <= en_cnt_ff + 2'b01;
                    if (en_cnt_ff == LINK_EN_CYC - 2'b01) begin
                        link_en_ff  <= 1'b1;
                        chan0_alloc <= 1'b1;
                        state_ff    <= ST_LK_ACK;
                    end
                end
                ST_LK_ACK:
                    if (lk_vld_ff && !lk_ctl_ff) begin
                        ack_ff  <= {lk_byte_ff, ack_ff[31:8]};
                        acnt_ff <= acnt_ff + 2'b01;
                        if (acnt_ff == 2'b11) state_ff <= ST_LOAD;
                    end
                ST_LOAD:
                    if (img_done_ff) begin
                        state_ff <= (src_ff == SRC_LINK) ? ST_LK_ENDIN
                                                         : ST_CHECK;
                    end
                ST_LK_ENDIN:
                    if (lk_vld_ff && lk_ctl_ff && lk_byte_ff == TOK_END) begin
                        state_ff <= ST_LK_ENDOUT;
                    end
                ST_LK_ENDOUT:
                    if (ack_ff == NULL_CHAN || ltx_done_ff) begin
                        chan0_alloc <= 1'b0;
                        state_ff    <= ST_CHECK;
                    end
                ST_CHECK: state_ff <= img_ok ? ST_JUMP : ST_FAIL;
                ST_JUMP: begin
                    core_rst_n <= 1'b1;
                    jump       <= 1'b1;
                    jump_addr  <= RAM_START;
                end
                ST_FAIL: crc_fail <= 1'b1;
                default: state_ff <= ST_RST;
            endcase
        end
    end

    // ========================================================
    // SPI master on fixed pins, mode 0, low bit first
    assign spi_on = (state_ff == ST_SPI_CMD)
                 || (state_ff == ST_LOAD && src_ff == SRC_SPI);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            spi         <= '{sclk: 1'b0, ss_n: 1'b1, mosi: 1'b0};
            spi_oe_n    <= 1'b1;
            div_ff      <= 4'h0;
            scnt_ff     <= 6'h00;
            tx_ff       <= 32'h0;
            srx_ff      <= 8'h00;
            sbyte_ff    <= 8'h00;
            spi_vld_ff  <= 1'b0;
            cmd_done_ff <= 1'b0;
        end else begin
            spi_vld_ff  <= 1'b0;
            cmd_done_ff <= 1'b0;
            if (src_ff == SRC_SPI) spi_oe_n <= 1'b0;
            if (!spi_on) begin
                spi.sclk <= 1'b0;
                spi.ss_n <= 1'b1;
                spi.mosi <= 1'b0;
                div_ff   <= 4'h0;
                scnt_ff  <= 6'h00;
                if (state_ff == ST_SEL) tx_ff <= {SPI_ADDR, SPI_READ};
            end else begin
                spi.ss_n <= 1'b0;
                spi.mosi <= tx_ff[0];
                if (div_ff == SPI_HALF_CYC - 4'h1) begin
                    div_ff   <= 4'h0;
                    spi.sclk <= ~spi.sclk;
                    if (spi.sclk) begin
                        // Falling edge: synced data is the rising-edge level
                        tx_ff   <= tx_ff >> 1;
                        srx_ff  <= {sync2_ff[SY_MISO], srx_ff[7:1]};
                        scnt_ff <= scnt_ff + 6'h01;
                        if (state_ff == ST_SPI_CMD && scnt_ff == 6'h1f) begin
                            cmd_done_ff <= 1'b1;
                        end
                        if (state_ff == ST_LOAD && scnt_ff[2:0] == 3'h7) begin
                            spi_vld_ff <= 1'b1;
                            sbyte_ff   <= {sync2_ff[SY_MISO], srx_ff[7:1]};
                        end
                    end
                end else begin
                    div_ff <= div_ff + 4'h1;
                end
            end
        end
    end

    // ========================================================
    // Boot link, sampled on rising edges of the link clock
    assign lclk_rise = sync2_ff[SY_LCLK] && !lclk_d_ff;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lclk_d_ff   <= 1'b0;
            lbit_ff     <= 3'h0;
            lsh_ff      <= 8'h00;
            lk_byte_ff  <= 8'h00;
            lk_vld_ff   <= 1'b0;
            lk_ctl_ff   <= 1'b0;
            ltx_cnt_ff  <= 4'h0;
            ltx_done_ff <= 1'b0;
            link_out    <= 2'b00;
            link_oe_n   <= 1'b1;
            link_pd_en  <= 1'b1;
        end else begin
            lclk_d_ff <= sync2_ff[SY_LCLK];
            lk_vld_ff <= 1'b0;
            if (link_en_ff) begin
                link_pd_en <= 1'b0;
                link_oe_n  <= 1'b0;
            end
            if (lclk_rise && link_en_ff && state_ff != ST_LK_ENDOUT) begin
                lbit_ff <= lbit_ff + 3'h1;
                lsh_ff  <= {sync2_ff[SY_LIN0], lsh_ff[7:1]};
                if (lbit_ff == 3'h7) begin
                    lk_vld_ff  <= 1'b1;
                    lk_byte_ff <= {sync2_ff[SY_LIN0], lsh_ff[7:1]};
                    lk_ctl_ff  <= sync2_ff[SY_LIN1];
                end
            end
            if (lclk_rise && state_ff == ST_LK_ENDOUT
                && ack_ff != NULL_CHAN && !ltx_done_ff) begin
                ltx_cnt_ff <= ltx_cnt_ff + 4'h1;
                if (ltx_cnt_ff == 4'h8) begin
                    link_out    <= 2'b00;
                    ltx_done_ff <= 1'b1;
                end else begin
                    link_out <= {1'b1, TOK_END[ltx_cnt_ff[2:0]]};
                end
            end
        end
    end

    // ========================================================
    // OTP reader
    always_comb begin
        otp_byte = otp_word_ff[7:0];
        case (ob_ff)
            // Valid flag lags the byte counter by one cycle
            3'h5:    otp_byte = otp_word_ff[15:8];
            3'h6:    otp_byte = otp_word_ff[23:16];
            3'h0:    otp_byte = otp_word_ff[31:24];
            default: otp_byte = otp_word_ff[7:0];
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ob_ff       <= 3'h0;
            otp_rd      <= 1'b0;
            otp_addr    <= OTP_START;
            otp_word_ff <= 32'h0;
            otp_vld_ff  <= 1'b0;
        end else begin
            otp_rd     <= 1'b0;
            otp_vld_ff <= 1'b0;
            if (state_ff == ST_LOAD && src_ff == SRC_OTP
                && ph_ff != PH_DONE) begin
                ob_ff <= (ob_ff == 3'h6) ? 3'h0 : ob_ff + 3'h1;
                if (ob_ff == 3'h0) otp_rd <= 1'b1;
                if (ob_ff == 3'h2) otp_word_ff <= otp_rdata;
                if (ob_ff >= 3'h3) otp_vld_ff <= 1'b1;
                if (ob_ff == 3'h6) otp_addr <= otp_addr + 11'h001;
            end else if (state_ff == ST_SEL) begin
                ob_ff    <= 3'h0;
                otp_addr <= OTP_START;
            end
        end
    end

    // ========================================================
    // Image parser, CRC and RAM writes
    always_comb begin
        src_vld  = 1'b0;
        src_byte = 8'h00;
        case (src_ff)
            SRC_SPI: begin
                src_vld  = spi_vld_ff;
                src_byte = sbyte_ff;
            end
            SRC_LINK: begin
                src_vld  = lk_vld_ff && !lk_ctl_ff;
                src_byte = lk_byte_ff;
            end
            SRC_OTP: begin
                src_vld  = otp_vld_ff;
                src_byte = otp_byte;
            end
            default: src_vld = 1'b0;
        endcase
        src_vld  = src_vld && state_ff == ST_LOAD;
        nxt_word = {src_byte, word_ff[31:8]};
        nxt_crc  = crc_upd(crc_ff, src_byte);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ph_ff       <= PH_SIZE;
            bc_ff       <= 2'b00;
            word_ff     <= 32'h0;
            size_ff     <= 32'h0;
            bytes_ff    <= 32'h0;
            crc_ff      <= CRC_INIT;
            rx_crc_ff   <= 32'h0;
            img_done_ff <= 1'b0;
            ram         <= '0;
        end else begin
            img_done_ff <= 1'b0;
            ram.we      <= 1'b0;
            if (state_ff == ST_SEL) begin
                ph_ff    <= PH_SIZE;
                bc_ff    <= 2'b00;
                bytes_ff <= 32'h0;
                crc_ff   <= CRC_INIT;
            end else if (src_vld) begin
                case (ph_ff)
                    PH_SIZE: begin
                        crc_ff  <= nxt_crc;
                        word_ff <= nxt_word;
                        bc_ff   <= bc_ff + 2'b01;
                        if (bc_ff == 2'b11) begin
                            size_ff <= nxt_word;
                            ph_ff   <= (nxt_word == 32'h0) ? PH_CRC : PH_PROG;
                        end
                    end
                    PH_PROG: begin
                        crc_ff    <= nxt_crc;
                        ram.we    <= 1'b1;
                        ram.addr  <= RAM_START + bytes_ff[15:0];
                        ram.data  <= src_byte;
                        bytes_ff  <= bytes_ff + 32'h1;
                        if (bytes_ff + 32'h1 == {size_ff[29:0], 2'b00}) begin
                            ph_ff <= PH_CRC;
                        end
                    end
                    PH_CRC: begin
                        word_ff <= nxt_word;
                        bc_ff   <= bc_ff + 2'b01;
                        if (bc_ff == 2'b11) begin
                            rx_crc_ff   <= nxt_word;
                            img_done_ff <= 1'b1;
                            ph_ff       <= PH_DONE;
                        end
                    end
                    default: ph_ff <= PH_DONE;
                endcase
            end
        end
    end

    // ========================================================
    // Assertions
    hiz_reset_a: assert property (@(posedge clk)
        disable iff (!nrst) state_ff == ST_RST |-> gpio_hiz && !gpio_pull_en)
        else $error("pins left high impedance state early");
    phase_len_a: assert property (@(posedge clk)
        disable iff (!nrst) $rose(gpio_pull_en) |-> rst_cnt_ff == RST_CYC)
        else $error("reset phase length wrong");
    strap_spi_a: assert property (@(posedge clk)
        disable iff (!nrst) state_ff == ST_SEL && !security_reg[SEC_BOOT_BIT]
        && sync2_ff[SY_STR+1:SY_STR] == BS_SPI
        |=> state_ff == ST_SPI_CMD ##0 src_ff == SRC_SPI)
        else $error("SPI strap not honoured");
    otp_start_a: assert property (@(posedge clk)
        disable iff (!nrst) state_ff == ST_SEL && security_reg[SEC_BOOT_BIT]
        |-> ##2 otp_rd && otp_addr == OTP_START)
        else $error("secure boot did not read OTP word 0");
    spi_idle_a: assert property (@(posedge clk)
        disable iff (!nrst) spi.ss_n |-> !spi.sclk)
        else $error("SPI clock not low while deselected");
    first_wr_a: assert property (@(posedge clk)
        disable iff (!nrst) src_vld && ph_ff == PH_PROG && bytes_ff == 32'h0
        |=> ram.we && ram.addr == RAM_START)
        else $error("first program byte not at lowest address");
    link_delay_a: assert property (@(posedge clk)
        disable iff (!nrst) $rose(state_ff == ST_LK_EN)
        |-> !link_en_ff ##2 $rose(link_en_ff))
        else $error("link enable delay wrong");
    link_idle_a: assert property (@(posedge clk)
        disable iff (!nrst) $rose(link_en_ff)
        |=> !link_pd_en && link_out == 2'b00)
        else $error("link not idle low when enabled");
    bad_crc_a: assert property (@(posedge clk)
        disable iff (!nrst) state_ff == ST_CHECK && !img_ok
        |-> ##2 crc_fail && !jump)
        else $error("jump taken after CRC mismatch");
endmodule : tbs_top

/* File: verif/tbs_flash_model.sv */
// SPI flash partner model serving a boot image
`timescale 1ns/1ns
module tbs_flash_model (
    input  wire logic   sclk,
    input  wire logic   ss_n,
    input  wire logic   mosi,
    output logic        miso,
    output logic [31:0] cmd
);
    // ====================
    // Command in, data out
    logic [7:0] img [12];
    int         n = 0;
    initial miso = 1'b0;
    always @(posedge sclk or posedge ss_n) begin
        if (ss_n)
            n <= 0;
        else begin
            if (n < 32) cmd[n] <= mosi;
            n <= n + 1;
        end
    end
    // Toggles while not driving so stale data never looks valid
    always @(negedge sclk or posedge ss_n) begin
        if (ss_n || n < 32 || n > 127)
            miso <= ~miso;
        else
            miso <= img[(n-32)/8][(n-32)%8];
    end
endmodule : tbs_flash_model

/* File: verif/tbs_top_tb_top.sv */
// Self-checking bench for the tile boot sequencer
`timescale 1ns/1ns
module tbs_top_tb_top;
    import tbs_pkg::*;
    // ===================
    // Signals and devices
    logic        clk = 0, nrst = 0, lclk = 0, spi_miso, spi_oe_n, link_oe_n;
    logic        link_pd_en, gpio_hiz, gpio_pull_en, otp_rd, core_rst_n;
    logic        jump, crc_fail, wait_test, seen, chan0_alloc;
    logic [1:0]  boot_src_strap = 0, pr = 0, link_out, lin = 0;
    logic [31:0] security_reg = 0, cmd, ow [4];
    logic [15:0] jump_addr, pll_mult, rx;
    logic [10:0] otp_addr, oa0;
    logic [7:0]  mem [4];
    logic [7:0]  img [8] = '{8'h01, 0, 0, 0, 8'ha1, 8'hb2, 8'hc3, 8'hd4};
    tbs_spi_s    spi;
    tbs_ram_s    ram;
    int          failures = 0, n_checks = 0;
    initial forever #50 clk = ~clk;
    tbs_top dut_u (.clk, .nrst, .boot_src_strap, .pll_ratio_strap_low(pr[0]),
        .pll_ratio_strap_high(pr[1]), .security_reg, .spi_miso, .spi,
        .link_clk(lclk), .link_in(lin), .otp_rdata(ow[otp_addr[1:0]]),
        .spi_oe_n,
        .link_out, .link_oe_n, .link_pd_en, .gpio_hiz, .gpio_pull_en, .otp_rd,
        .otp_addr, .ram, .core_rst_n, .jump, .jump_addr, .crc_fail,
        .wait_test, .chan0_alloc, .pll_mult);
    tbs_flash_model fl_u (.sclk(spi.sclk), .ss_n(spi.ss_n), .mosi(spi.mosi),
        .miso(spi_miso), .cmd);
    always @(posedge clk) begin
        if (!nrst) begin
            seen <= 1'b0;
            mem  <= '{default: 8'h00};
        end else begin
            if (ram.we && ram.addr < 4) mem[ram.addr[1:0]] <= ram.data;
            if (otp_rd && !seen) {seen, oa0} <= {1'b1, otp_addr};
        end
    end
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic boot(logic [1:0] s, logic [1:0] p, logic [31:0] sv);
        @(negedge clk);
        {nrst, boot_src_strap, pr, security_reg} = {1'b0, s, p, sv};
        repeat (3) @(negedge clk);
        chk("hiz in reset", 1, gpio_hiz);
        nrst = 1;
        repeat (140) @(negedge clk);
        chk("hiz in phase", 1, gpio_hiz);
        repeat (20) @(negedge clk);
        chk("pulls on", 1, gpio_pull_en);
    endtask : boot
    task automatic t_modes();
        logic [15:0] r [4] = '{16'h0c03, 16'h0190, 16'h0341, 16'h07d0};
        for (int i = 0; i < 4; i++) begin
            boot(2'(i), 2'(i), 0);
            chk("pll ratio", r[i], pll_mult);
            chk("test wait", i < 2, wait_test);
            chk("spi oe", i != 3, spi_oe_n);
            if (i == 2) chk("link idle", 0, {link_out, link_pd_en, link_oe_n});
        end
        $display("TB: modes done");
    endtask : t_modes
    function automatic logic [31:0] crc32();
        logic [31:0] c = 32'hffffffff;
        for (int i = 0; i < 64; i++)
            c = (c[0] ^ img[i/8][i%8]) ? (c >> 1) ^ 32'hedb88320 : c >> 1;
        return ~c;
    endfunction : crc32
    task automatic fin(logic ok);
        for (int i = 0; i < 3000 && !(jump || crc_fail); i++) @(negedge clk);
        repeat (4) @(negedge clk);
        for (int i = 0; i < 4; i++) chk("ram byte", img[4+i], mem[i]);
        chk("jump", ok, jump);
        chk("crc fail", !ok, crc_fail);
        chk("core run", {ok, 16'h0}, {core_rst_n, jump_addr});
    endtask : fin
    task automatic t_spi(logic [31:0] cw, logic ok);
        for (int i = 0; i < 8; i++) fl_u.img[i] = img[i];
        for (int i = 0; i < 4; i++) fl_u.img[8+i] = cw[8*i +: 8];
        boot(2'b11, 2'b00, 0);
        fin(ok);
        chk("read cmd", 32'h3, cmd);
        chk("bus idle", 2'b01, {spi.sclk, spi.ss_n});
        $display("TB: spi boot done");
    endtask : t_spi
    task automatic t_otp();
        ow = '{32'h1, 32'hd4c3b2a1, crc32(), 32'h0};
        boot(2'b11, 2'b00, 32'h20);
        chk("otp start", 13'h1001, {seen, oa0, spi_oe_n});
        fin(1);
        $display("TB: otp boot done");
    endtask : t_otp
    // Link clock only runs while a byte is sent
    task automatic lbyte(logic [7:0] b, logic f);
        for (int i = 0; i < 8; i++) begin
            lin = {f, b[i]};
            repeat (4) @(negedge clk);
            lclk = 1'b1;
            repeat (4) @(negedge clk);
            lclk = 1'b0;
            rx = {link_out, rx[15:2]};
        end
    endtask : lbyte
    task automatic t_link(logic [31:0] ack, logic [15:0] tx);
        logic [31:0] cw;
        cw = crc32();
        boot(2'b10, 2'b00, 0);
        for (int i = 0; i < 4; i++) lbyte(ack[8*i +: 8], 0);
        chk("chan0 held", 1, chan0_alloc);
        for (int i = 0; i < 8; i++) lbyte(img[i], 0);
        for (int i = 0; i < 4; i++) lbyte(cw[8*i +: 8], 0);
        lbyte(8'h01, 1);
        lbyte(8'h00, 0);
        chk("end token out", tx, rx);
        lbyte(8'h00, 0);
        chk("chan0 freed", 0, chan0_alloc);
        fin(1);
        $display("TB: link boot done");
    endtask : t_link
    task automatic results();
        $display("TB: checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    initial begin
        t_modes();
        t_spi(32'h0d15ab1e, 1);
        t_spi(crc32(), 1);
        t_spi(32'h0, 0);
        t_otp();
        t_link(32'h0000ff02, 16'h0000);
        t_link(32'h00000102, 16'haaab);
        results();
    end
    initial begin
        #2000000;
        failures++;
        results();
    end
endmodule : tbs_top_tb_top
